// file: verilog/selftest_pkg.sv
package selftest_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_PAGE_SELECT   = 8'h4C;
   localparam logic [7:0] ADDR_ERROR_COUNT   = 8'h57;
   localparam logic [7:0] ADDR_CONTROL       = 8'hB3;
   localparam logic [7:0] ADDR_DEBUG         = 8'hD0;
   localparam logic [7:0] ADDR_GPIO_FUNC     = 8'h10;
   localparam logic [7:0] PORT_PAGE_LO       = 8'h46;
   localparam logic [7:0] PORT_PAGE_HI       = 8'h7D;
   localparam logic [7:0] DEBUG_PAGE_LO      = 8'hD0;
   localparam logic [7:0] DEBUG_PAGE_HI      = 8'hDB;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int         NUM_PORTS          = 4;
   localparam int         NUM_GPIO           = 4;
   localparam int         PAGE_RD_LSB        = 4;
   localparam int         CTRL_ENABLE_BIT    = 0;
   localparam int         CTRL_CLKSEL_LSB    = 1;
   localparam int         CTRL_GATING_LSB    = 6;
   localparam int         DEBUG_REMOTE_BIT   = 5;
   localparam logic [7:0] CTRL_START_VALUE   = 8'h01;
   localparam logic [1:0] GATING_DISABLED    = 2'h0;
   localparam logic [1:0] GATING_ENABLED     = 2'h2;
   localparam logic [7:0] PAGE_RESET         = 8'h00;
   localparam logic [7:0] CONTROL_RESET      = 8'h00;
   localparam logic [7:0] COUNT_MAX_NORMAL   = 8'hFE;
   localparam logic [7:0] COUNT_NO_LOCK      = 8'hFF;
   localparam logic [7:0] REMOTE_MODE_REG    = 8'h14;
   localparam logic [7:0] REMOTE_BIST_REG    = 8'hB3;
   localparam logic [2:0] GPIO_FUNC_PASS     = 3'h1;
   localparam logic [2:0] GPIO_FUNC_LOCK     = 3'h2;

   // ----------------------------------------------------------------
   // back channel timing
   // ----------------------------------------------------------------
   localparam int         CLK_MHZ            = 40;
   localparam int         BC_BIT_NS          = 500;
   localparam int         BC_BIT_CYCLES      = (BC_BIT_NS * CLK_MHZ) / 1000;

endpackage

// file: verilog/backchannel_writer.sv
`timescale 1ns/1ps
`default_nettype none
// serialises one remote register write: start bit, addr, data, stop
module backchannel_writer
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       start,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] data,
   output logic            busy,
   output logic            tx
);
   typedef enum logic [1:0] {IDLE, SEND} wstate_e;
   typedef struct packed
   {
      wstate_e     st;
      logic [17:0] sh;
      logic [4:0]  bits;
      logic [15:0] div;
      logic        tx;
   } wr_s;

   wr_s r, n;

   // ----------------------------------------------------------------
   // shift engine, one bit per divider tick
   // ----------------------------------------------------------------
   always_comb
   begin
      n = r;
      unique case (r.st)
         IDLE:
         begin
            n.tx = 1'b1;
            if (start)
            begin
               n.sh   = {1'b1, data, addr, 1'b0};
               n.bits = 5'd18;
               n.div  = 16'(selftest_pkg::BC_BIT_CYCLES - 1);
               n.st   = SEND;
            end
         end
         SEND:
         begin
            n.tx = r.sh[0];
            if (r.div == 16'h0000)
            begin
               n.div  = 16'(selftest_pkg::BC_BIT_CYCLES - 1);
               n.sh   = {1'b1, r.sh[17:1]};
               n.bits = r.bits - 5'd1;
               if (r.bits == 5'd1)
                  n.st = IDLE;
            end
            else
               n.div = r.div - 16'd1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         r <= '{st: IDLE, sh: 18'h3FFFF, bits: 5'h00, div: 16'h0000,
                tx: 1'b1};
      else
         r <= n;
   end

   assign busy = (r.st != IDLE);
   assign tx   = r.tx;
endmodule
`default_nettype wire

// file: verilog/prbs_checker.sv
`timescale 1ns/1ps
`default_nettype none
// one receive port: sampled link clock, prbs7 check on each word
module prbs_checker
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       link_clk,
   input  wire logic       link_data,
   input  wire logic       lock,
   input  wire logic       run,
   input  wire logic       clear,
   output logic [7:0]      count,
   output logic            err_pulse,
   output logic            lock_s
);
   typedef struct packed
   {
      logic [2:0] ck;
      logic [2:0] dt;
      logic [2:0] lk;
      logic       ck_prev;
      logic [6:0] lfsr;
      logic [2:0] bitn;
      logic       word_bad;
      logic       seen_lock;
      logic       lost;
      logic [7:0] cnt;
      logic       err;
   } chk_s;

   chk_s r, n;
   logic fb;
   logic rise;
   logic bit_bad;

   // ----------------------------------------------------------------
   // three-flop sync; a change counts when stages two and three agree
   // ----------------------------------------------------------------
   always_comb
   begin
      n       = r;
      n.ck    = {r.ck[1:0], link_clk};
      n.dt    = {r.dt[1:0], link_data};
      n.lk    = {r.lk[1:0], lock};
      n.err   = 1'b0;
      fb      = r.lfsr[6] ^ r.lfsr[5];
      rise    = (r.ck[1] == r.ck[2]) && r.ck[2] && !r.ck_prev;
      bit_bad = (r.dt[2] != fb);
      if (r.ck[1] == r.ck[2])
         n.ck_prev = r.ck[2];
      if (clear)
      begin
         n.cnt       = 8'h00;
         n.seen_lock = 1'b0;
         n.lost      = 1'b0;
         n.bitn      = 3'h0;
         n.word_bad  = 1'b0;
         n.lfsr      = 7'h7F;
      end
      else if (run)
      begin
         if (r.lk[2])
            n.seen_lock = 1'b1;
         else if (r.seen_lock)
            n.lost = 1'b1;
         // self-synchronising: the received bit reloads the lfsr
         if (rise && r.lk[2])
         begin
            n.lfsr     = {r.lfsr[5:0], r.dt[2]};
            n.word_bad = r.word_bad | bit_bad;
            n.bitn     = r.bitn + 3'h1;
            if (r.bitn == 3'h7)
            begin
               n.word_bad = 1'b0;
               if (r.word_bad | bit_bad)
               begin
                  n.err = 1'b1;
                  if (r.cnt < selftest_pkg::COUNT_MAX_NORMAL)
                     n.cnt = r.cnt + 8'h01;
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         r <= '0;
      else
         r <= n;
   end

   // no lock ever, or lock dropped: report the reserved code
   assign count     = (!r.seen_lock || r.lost) ?
                      selftest_pkg::COUNT_NO_LOCK : r.cnt;
   assign err_pulse = r.err;
   assign lock_s    = r.lk[2];
endmodule
`default_nettype wire

// file: verilog/serial_link_selftest.sv
`timescale 1ns/1ps
`default_nettype none
module serial_link_selftest
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   input  wire logic [3:0] link_clk,
   input  wire logic [3:0] link_data,
   input  wire logic [3:0] rx_lock,
   input  wire logic       remote_ack,
   input  wire logic [3:0] recovered_serial,
   input  wire logic       pattern_gen_on,
   input  wire logic [3:0] video_lane_in,
   output logic [3:0]      backchannel_tx,
   output logic [3:0]      gpio_out,
   output logic [3:0]      gpio_oe,
   output logic [3:0]      lane_out,
   output logic            lane_lp11,
   output logic [3:0]      serial_monitor_output
);
   typedef enum logic [2:0] {S_IDLE, S_CLK, S_CLK_WAIT, S_MODE, S_MODE_WAIT,
                             S_RUN, S_STOP, S_STOP_WAIT} seq_e;
   typedef struct packed
   {
      seq_e       st;
      logic [7:0] page;
      logic [7:0] ctrl;
      logic [1:0] clksel;
      logic       running;
      logic [3:0] remote_act;
      logic [2:0] ack_sync;
      logic       clear;
      logic [7:0] rdata;
      logic [11:0] gfunc;
      logic [3:0] gout;
      logic [3:0] goe;
      logic [3:0] lanes;
      logic       lp11;
      logic [3:0] mon;
      logic       bc_go;
      logic [7:0] bc_addr;
      logic [7:0] bc_data;
   } top_s;

   top_s r, n;
   logic [7:0] cnt     [selftest_pkg::NUM_PORTS];
   logic [3:0] err_p;
   logic [3:0] lock_s;
   logic       bc_busy;
   logic       bc_line;
   logic       ack_rise;
   logic [1:0] rsel;
   logic       outs_on;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // true when the address falls in a per-port paged window
   function automatic logic paged(input logic [7:0] a);
      paged = (a >= selftest_pkg::PORT_PAGE_LO &&
               a <= selftest_pkg::PORT_PAGE_HI) ||
              (a >= selftest_pkg::DEBUG_PAGE_LO &&
               a <= selftest_pkg::DEBUG_PAGE_HI);
   endfunction

   // ----------------------------------------------------------------
   // per-port checkers
   // ----------------------------------------------------------------
   for (genvar p = 0; p < selftest_pkg::NUM_PORTS; p++)
   begin : g_port
      prbs_checker u_chk
      (
         .clk       (clk),
         .resetn    (resetn),
         .link_clk  (link_clk[p]),
         .link_data (link_data[p]),
         .lock      (rx_lock[p]),
         .run       (r.running),
         .clear     (r.clear),
         .count     (cnt[p]),
         .err_pulse (err_p[p]),
         .lock_s    (lock_s[p])
      );
   end

   // one writer shared; every frame reaches all four links
   backchannel_writer u_bc
   (
      .clk    (clk),
      .resetn (resetn),
      .start  (r.bc_go),
      .addr   (r.bc_addr),
      .data   (r.bc_data),
      .busy   (bc_busy),
      .tx     (bc_line)
   );

   assign rsel     = r.page[selftest_pkg::PAGE_RD_LSB +: 2];
   assign ack_rise = r.ack_sync[1] & r.ack_sync[2];
   assign outs_on  = !r.running ||
                     (r.ctrl[selftest_pkg::CTRL_GATING_LSB +: 2] ==
                      selftest_pkg::GATING_ENABLED);

   // ----------------------------------------------------------------
   // register access, sequencer and pin muxing
   // ----------------------------------------------------------------
   always_comb
   begin
      n          = r;
      n.bc_go    = 1'b0;
      n.clear    = 1'b0;
      n.ack_sync = {r.ack_sync[1:0], remote_ack};
      // writes; only page select, control and the gpio function registers take writes
      if (reg_wr)
      begin
         if (reg_addr == selftest_pkg::ADDR_PAGE_SELECT)
            n.page = reg_wdata;
         else if (reg_addr == selftest_pkg::ADDR_CONTROL)
            n.ctrl = reg_wdata;
         else if (reg_addr >= selftest_pkg::ADDR_GPIO_FUNC &&
                  reg_addr < selftest_pkg::ADDR_GPIO_FUNC + 8'h04)
            n.gfunc[3 * reg_addr[1:0] +: 3] = reg_wdata[2:0];
      end
      // reads; error count and debug follow the read-select field, other paged addresses read zero
      n.rdata = 8'h00;
      if (reg_rd)
      begin
         if (reg_addr == selftest_pkg::ADDR_PAGE_SELECT)
            n.rdata = r.page;
         else if (reg_addr == selftest_pkg::ADDR_CONTROL)
            n.rdata = r.ctrl;
         else if (reg_addr == selftest_pkg::ADDR_ERROR_COUNT)
            n.rdata = cnt[rsel];
         else if (reg_addr == selftest_pkg::ADDR_DEBUG)
            n.rdata = {2'b00, r.remote_act[rsel], 5'b00000};
         else if (reg_addr >= selftest_pkg::ADDR_GPIO_FUNC &&
                  reg_addr < selftest_pkg::ADDR_GPIO_FUNC + 8'h04)
            n.rdata = {5'b00000, r.gfunc[3 * reg_addr[1:0] +: 3]};
         else if (paged(reg_addr))
            n.rdata = 8'h00;
      end
      // sequencer: clock select, then mode, then run
      unique case (r.st)
         S_IDLE:
            if (r.ctrl == selftest_pkg::CTRL_START_VALUE)
            begin
               n.clksel = r.ctrl[selftest_pkg::CTRL_CLKSEL_LSB +: 2];
               n.clear  = 1'b1;
               n.st     = S_CLK;
            end
         S_CLK:
            if (!bc_busy)
            begin
               n.bc_addr = selftest_pkg::REMOTE_MODE_REG;
               n.bc_data = {5'b00000, r.clksel, 1'b0};
               n.bc_go   = 1'b1;
               n.st      = S_CLK_WAIT;
            end
         S_CLK_WAIT:
            if (!bc_busy && !r.bc_go)
               n.st = S_MODE;
         S_MODE:
         begin
            n.bc_addr = selftest_pkg::REMOTE_BIST_REG;
            n.bc_data = selftest_pkg::CTRL_START_VALUE;
            n.bc_go   = 1'b1;
            n.st      = S_MODE_WAIT;
         end
         S_MODE_WAIT:
            if (!bc_busy && !r.bc_go)
            begin
               n.running = 1'b1;
               n.st      = S_RUN;
            end
         S_RUN:
         begin
            if (ack_rise)
               n.remote_act = r.page[3:0] | r.remote_act;
            if (r.ctrl[selftest_pkg::CTRL_ENABLE_BIT] == 1'b0)
            begin
               n.running = 1'b0;
               n.st      = S_STOP;
            end
         end
         S_STOP:
            if (!bc_busy)
            begin
               n.bc_addr = selftest_pkg::REMOTE_BIST_REG;
               n.bc_data = 8'h00;
               n.bc_go   = 1'b1;
               n.st      = S_STOP_WAIT;
            end
         S_STOP_WAIT:
            if (!bc_busy && !r.bc_go)
            begin
               n.remote_act = 4'h0;
               n.st         = S_IDLE;
            end
      endcase
      // gpio: pass level drops for each error, or shows port lock
      for (int g = 0; g < selftest_pkg::NUM_GPIO; g++)
      begin
         n.goe[g]  = 1'b0;
         n.gout[g] = 1'b0;
         if (r.gfunc[3 * g +: 3] == selftest_pkg::GPIO_FUNC_PASS)
         begin
            n.goe[g]  = 1'b1;
            n.gout[g] = r.running & !err_p[g];
         end
         else if (r.gfunc[3 * g +: 3] == selftest_pkg::GPIO_FUNC_LOCK)
         begin
            n.goe[g]  = 1'b1;
            n.gout[g] = lock_s[g];
         end
      end
      // camera lanes pass video when not running; while running they idle unless outputs allowed and pattern on
      n.lp11  = !(outs_on && (!r.running || pattern_gen_on));
      n.lanes = n.lp11 ? 4'hF : video_lane_in;
      // monitor is not gated by the test state
      n.mon   = recovered_serial;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         r       <= '0;
         r.st    <= S_IDLE;
         r.page  <= selftest_pkg::PAGE_RESET;
         r.ctrl  <= selftest_pkg::CONTROL_RESET;
         r.lp11  <= 1'b1;
         r.lanes <= 4'hF;
      end
      else
         r <= n;
   end

   // ----------------------------------------------------------------
   // outputs, all from flops
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         backchannel_tx <= 4'hF;
      else
         backchannel_tx <= {4{bc_line}};
   end

   assign reg_rdata             = r.rdata;
   assign gpio_out              = r.gout;
   assign gpio_oe               = r.goe;
   assign lane_out              = r.lanes;
   assign lane_lp11             = r.lp11;
   assign serial_monitor_output = r.mon;
endmodule
`default_nettype wire

// file: tb/selftest_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checker for the self-test block
// ----------------------------------------------------------------
module selftest_props
(
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [3:0] recovered_serial,
   input wire logic       pattern_gen_on,
   input wire logic [3:0] backchannel_tx,
   input wire logic [3:0] lane_out,
   input wire logic       lane_lp11,
   input wire logic [3:0] serial_monitor_output
);
   logic [7:0] ctl_r;
   logic [7:0] page_r;
   logic       ctl_wr;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // shadow copies of the page select and control registers, as written
   assign ctl_wr = reg_wr && reg_addr == selftest_pkg::ADDR_CONTROL;
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctl_r  <= 8'h00;
         page_r <= 8'h00;
      end
      else
      begin
         if (ctl_wr)
            ctl_r <= reg_wdata;
         if (reg_wr && reg_addr == selftest_pkg::ADDR_PAGE_SELECT)
            page_r <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   reset_values_a: assert property ($rose(resetn) |-> lane_lp11 &&
      lane_out == 4'hF && backchannel_tx == 4'hF)
      else $error("outputs not at reset values");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero without a read");
   page_read_a: assert property (reg_rd &&
      reg_addr == selftest_pkg::ADDR_PAGE_SELECT |=> reg_rdata == $past(page_r))
      else $error("page select readback wrong");
   control_read_a: assert property (reg_rd &&
      reg_addr == selftest_pkg::ADDR_CONTROL |=> reg_rdata == $past(ctl_r))
      else $error("control readback wrong");
   start_frame_a: assert property (ctl_wr && reg_wdata == 8'h01 &&
      !ctl_r[0] |-> ##[1:8] !backchannel_tx[0])
      else $error("no back channel frame after start");
   stop_frame_a: assert property (ctl_wr && !reg_wdata[0] &&
      ctl_r[0] |-> ##[1:8] !backchannel_tx[0])
      else $error("no back channel frame after stop");
   bc_start_bit_a: assert property ($fell(backchannel_tx[0]) |->
      !backchannel_tx[0] [*8])
      else $error("back channel start bit too short");
   bc_ports_same_a: assert property (
      backchannel_tx == {4{backchannel_tx[0]}})
      else $error("back channel ports differ");
   monitor_copy_a: assert property ($past(resetn) |->
      serial_monitor_output == $past(recovered_serial))
      else $error("monitor output not following serial input");
   lanes_idle_a: assert property (lane_lp11 |-> lane_out == 4'hF)
      else $error("lanes not at idle level while idle");
endmodule
`default_nettype wire

// file: tb/serializer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// remote serializer: decodes back channel writes, sends prbs7
// ----------------------------------------------------------------
module serializer_model
(
   input  wire logic       bc_line,
   input  wire logic [3:0] corrupt,
   output logic [3:0]      link_clk,
   output logic [3:0]      link_data,
   output logic            remote_ack
);
   logic [7:0]  fa [0:15];
   logic [7:0]  fd [0:15];
   int          frame_count = 0;
   logic [15:0] sh;
   logic [6:0]  lfsr;
   logic        nb;
   logic        active = 1'b0;
   logic        go = 1'b0;
   logic [1:0]  clk_src;

   assign remote_ack = active;

   // frame decode mid-bit; a bad stop bit drops the frame, standing
   // in for the frame check of the real remote
   always @(negedge bc_line)
   begin
      #250;
      for (int i = 0; i < 16; i++)
      begin
         #500;
         sh[i] = bc_line;
      end
      #500;
      if (bc_line === 1'b1)
      begin
         fa[frame_count[3:0]] = sh[7:0];
         fd[frame_count[3:0]] = sh[15:8];
         frame_count++;
         if (sh[7:0] == 8'h14)
            clk_src = sh[10:9];
         // the stream waits a while after the mode write, so that the
         // receiver's checker is armed before the first bit arrives
         if (sh[7:0] == 8'hB3)
         begin
            active = sh[8];
            go     = 1'b0;
            if (sh[8])
               go <= #2000 1'b1;
         end
      end
   end

   // link clock stands still between tests; data then toggles so a
   // stale bit never looks valid
   initial
   begin
      link_clk  = 4'h0;
      link_data = 4'h0;
      lfsr      = 7'h7F;
      forever
      begin
         #100;
         if (go)
         begin
            link_clk = ~link_clk;
            if (link_clk == 4'h0)
            begin
               nb = lfsr[6] ^ lfsr[5];
               lfsr = {lfsr[5:0], nb};
               link_data = {4{nb}} ^ corrupt;
            end
         end
         else if (active)
         begin
            // armed: first bit from the all-ones state stands ready
            link_clk  = 4'h0;
            link_data = corrupt;
            lfsr      = 7'h7E;
         end
         else
         begin
            link_clk  = 4'h0;
            link_data = ~link_data;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clk;
   logic       resetn;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [3:0] link_clk;
   logic [3:0] link_data;
   logic [3:0] rx_lock;
   logic [3:0] corrupt;
   logic       remote_ack;
   logic [3:0] backchannel_tx;
   logic [3:0] gpio_out;
   logic [3:0] gpio_oe;
   logic [3:0] lane_out;
   logic       lane_lp11;
   logic [3:0] serial_monitor_output;
   int         bad_count = 0;
   int         compares = 0;

   serial_link_selftest dut (.clk(clk), .resetn(resetn), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .link_clk(link_clk), .link_data(link_data),
      .rx_lock(rx_lock), .remote_ack(remote_ack),
      .recovered_serial(link_data), .pattern_gen_on(1'b0),
      .video_lane_in(4'h5), .backchannel_tx(backchannel_tx),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .lane_out(lane_out),
      .lane_lp11(lane_lp11), .serial_monitor_output(serial_monitor_output));
   serializer_model partner (.bc_line(backchannel_tx[0]), .corrupt(corrupt),
      .link_clk(link_clk), .link_data(link_data), .remote_ack(remote_ack));

   // ----------------------------------------------------------------
   // bus and compare helpers; inputs move 2 ns after the edge
   // ----------------------------------------------------------------
   task automatic check(input string w, input logic [7:0] e,
                        input logic [7:0] g);
      compares++;
      if (e !== g)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #2;
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e, input string w);
      @(posedge clk);
      #2;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #2;
      reg_rd = 1'b0;
      check(w, e, reg_rdata & m);
   endtask
   task automatic rdcnt(input logic [1:0] p, input logic [7:0] e);
      wr(8'h4C, {2'b00, p, 4'h0});
      rd(8'h57, 8'hFF, e, "error count");
   endtask
   // bounded wait; a frame takes some 360 cycles
   task automatic wait_frames(input int n);
      int k;
      k = 0;
      while (partner.frame_count < n && k < 3000)
      begin
         @(posedge clk);
         k++;
      end
      check("frame count", 8'(n), 8'(partner.frame_count));
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      check("lanes", 8'h1F, {3'h0, lane_lp11, lane_out});
      check("gpio enable", 8'h00, {4'h0, gpio_oe});
      rd(8'h4C, 8'hFF, 8'h00, "page select");
      rd(8'hB3, 8'hFF, 8'h00, "control");
      rd(8'h80, 8'hFF, 8'h00, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_clean;
      wr(8'h4C, 8'h0F);
      wr(8'h10, 8'h01);
      wr(8'h11, 8'h02);
      wr(8'h12, 8'h01);
      wr(8'h13, 8'h02);
      wr(8'hB3, 8'h01);
      wait_frames(2);
      check("frame0 addr", 8'h14, partner.fa[0]);
      check("frame0 data", 8'h00, partner.fd[0]);
      check("frame1 addr", 8'hB3, partner.fa[1]);
      check("frame1 data", 8'h01, partner.fd[1]);
      wr(8'hB3, 8'h07);
      repeat (6000) @(posedge clk);
      #2;
      check("frames", 8'h02, 8'(partner.frame_count));
      check("gpio", 8'hFF, {gpio_oe, gpio_out});
      rd(8'hD0, 8'h20, 8'h20, "remote active");
      wr(8'hB3, 8'h00);
      wait_frames(3);
      check("stop frame", 8'h00, partner.fd[2]);
      for (int p = 0; p < 4; p++)
         rdcnt(p[1:0], 8'h00);
      $display("test clean run done");
   endtask
   task automatic t_faults;
      int k;
      rx_lock = 4'h7;
      corrupt = 4'h1;
      wr(8'hB3, 8'h01);
      wait_frames(5);
      k = 0;
      // first see the pass level raised by the run, then its drop
      while (gpio_out[0] !== 1'b1 && k < 2000)
      begin
         @(posedge clk);
         #2;
         k++;
      end
      while (gpio_out[0] !== 1'b0 && k < 2000)
      begin
         @(posedge clk);
         #2;
         k++;
      end
      check("pass gpio", 8'h00, {7'h0, gpio_out[0]});
      check("lock gpio", 8'h01, {6'h0, gpio_out[3], gpio_out[1]});
      repeat (3000) @(posedge clk);
      #2;
      rx_lock[2] = 1'b0;
      repeat (100) @(posedge clk);
      #2;
      rx_lock[2] = 1'b1;
      repeat (17000) @(posedge clk);
      wr(8'hB3, 8'h00);
      wait_frames(6);
      rdcnt(2'd0, 8'hFE);
      rdcnt(2'd1, 8'h00);
      rdcnt(2'd2, 8'hFF);
      rdcnt(2'd3, 8'hFF);
      wr(8'h4C, 8'h0F);
      wr(8'h57, 8'h00);
      rdcnt(2'd0, 8'hFE);
      rx_lock = 4'hF;
      corrupt = 4'h0;
      $display("test faults done");
   endtask
   task automatic t_restart;
      wr(8'hB3, 8'h01);
      wait_frames(8);
      repeat (1000) @(posedge clk);
      wr(8'hB3, 8'h00);
      wait_frames(9);
      rdcnt(2'd0, 8'h00);
      $display("test restart done");
   endtask

   task automatic conclude;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // clock, watchdog and main sequence
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      bad_count++;
      conclude;
   end
   initial
   begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      rx_lock = 4'hF;
      corrupt = 4'h0;
      repeat (2) @(posedge clk);
      #2;
      resetn = 1'b1;
      t_reset;
      t_clean;
      t_faults;
      t_restart;
      conclude;
   end
endmodule

bind serial_link_selftest selftest_props chk (.clk(clk), .resetn(resetn),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .recovered_serial(recovered_serial), .pattern_gen_on(pattern_gen_on),
   .backchannel_tx(backchannel_tx), .lane_out(lane_out),
   .lane_lp11(lane_lp11), .serial_monitor_output(serial_monitor_output));
`default_nettype wire
